/* File: design/spi_status_params.svh */
// Offsets, field positions and reset values of the SPI status block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
// Function
// - Manual mode: done when units reach length
// - DMA mode: done together with DMA-done
// - Descriptor mode: done after last descriptor only
// - Stop: finish current byte, then done
// - Done resets zero, cleared writing one
// - Receive byte count in bits 31:16
// - Transmit byte count in bits 15:0
// - Enables 14 and 12 gate rx request/full
// - Enable 13 gates rx empty, resets one
// - Enables 10, 9, 8 gate tx sources
// - Enables 4, 3, 2 gate error sources
// - Enables 1 and 0 gate DMA, done
// - Rx request when count >= rx trigger, trigger nonzero
// - Tx request when count <= tx trigger, trigger nonzero
// - Tx port write adds size; full overflows
// - Rx port read subtracts; empty underflows
`ifndef SPI_STATUS_PARAMS_SVH
`define SPI_STATUS_PARAMS_SVH
`define OFF_CONTROL 8'h00
`define OFF_STATUS 8'h10
`define OFF_COUNTS 8'h14
`define OFF_ENABLES 8'h18
`define OFF_TRIGGERS 8'h1C
`define OFF_TX_PORT 8'h20
`define OFF_RX_PORT 8'h24
`define BIT_DONE 0
`define BIT_DMA 1
`define BIT_TX_ERR 2
`define BIT_RX_ERR 3
`define BIT_PROG_ERR 4
`define BIT_TX_FULL 8
`define BIT_TX_EMPTY 9
`define BIT_TX_REQ 10
`define BIT_RX_FULL 12
`define BIT_RX_EMPTY 13
`define BIT_RX_REQ 14
`define CTL_STOP 0
`define CTL_DMA_EN 1
`define CTL_DESC_EN 2
`define ENABLES_RESET 32'h0000_2000
`define ENABLES_MASK 32'h0000_771F
`define TRIGGERS_RESET 32'h0000_0000
`define CONTROL_RESET 32'h0000_0000
`endif

/* File: design/spi_status_pkg.sv */
// Types shared by the SPI status block.
// Assumes nothing of its surroundings.
package spi_status_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_STOP = 2'b11
  } xfer_state_t;
  typedef logic [2:0] access_size_t;
endpackage

/* File: design/fill_counter.sv */
// Byte occupancy counter of one data buffer.
// Assumes the adding and taking sides present amounts of 1, 2 or 4 bytes.
`timescale 1ns/1ps
module fill_counter #(
  parameter int CW = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic add_en_i,
  input wire spi_status_pkg::access_size_t add_amt_i,
  input wire logic sub_en_i,
  input wire spi_status_pkg::access_size_t sub_amt_i,
  output logic [CW-1:0] count_o,
  output logic full_o,
  output logic empty_o,
  output logic over_o,
  output logic under_o
);
  localparam logic [CW:0] DEPTH_W = (CW+1)'(DEPTH);
  logic [CW:0] count_q;
  logic [CW:0] count_d;
  logic add_ok;
  logic sub_ok;
  // Refused accesses leave the count untouched
  assign add_ok = add_en_i && (count_q + (CW+1)'(add_amt_i) <= DEPTH_W);
  assign sub_ok = sub_en_i && (count_q >= (CW+1)'(sub_amt_i));
  assign over_o = add_en_i && !add_ok;
  assign under_o = sub_en_i && !sub_ok;
  always_comb begin
    count_d = count_q;
    if (add_ok) begin
      count_d = count_d + (CW+1)'(add_amt_i);
    end
    if (sub_ok) begin
      count_d = count_d - (CW+1)'(sub_amt_i);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
  assign count_o = count_q[CW-1:0];
  assign full_o = (count_q == DEPTH_W);
  assign empty_o = (count_q == '0);
endmodule // fill_counter

/* File: design/sticky_flags.sv */
// Sticky event flags, set by hardware and cleared by writing one.
// Assumes set and clear are one-cycle pulses in the same clock.
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flag_o
);
  for (genvar i = 0; i < W; i++) begin : g_flag
    // Set beats a clear in the same cycle so no event is lost
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flag_o[i] <= 1'b0;
      end else begin
        flag_o[i] <= set_i[i] | (flag_o[i] & ~clr_i[i]);
      end
    end
  end
endmodule // sticky_flags

/* File: design/spi_status_irq.sv */
// Status, buffer counts, watermarks and interrupt of the SPI master.
// Assumes the shift engine gives byte and unit pulses on this clock.
`timescale 1ns/1ps
`include "spi_status_params.svh"
module spi_status_irq #(
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic start_i,
  input wire logic unit_done_i,
  input wire logic byte_end_i,
  input wire logic dma_done_i,
  input wire logic desc_done_i,
  input wire logic desc_last_i,
  input wire logic prog_err_i,
  input wire logic tx_pop_i,
  input wire logic rx_push_i,
  input wire logic [7:0] rx_data_i,
  output logic [31:0] tx_data_o,
  output logic [2:0] tx_size_o,
  output logic tx_wr_o,
  output logic rx_rd_o,
  output logic stop_req_o,
  output logic dma_en_o,
  output logic desc_en_o,
  output logic irq_o
);
  localparam int NS = 5;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic spi_status_pkg::access_size_t size_of(input logic [3:0] s);
    case (s)
      4'hF: size_of = 3'h4;
      4'h3: size_of = 3'h2;
      default: size_of = 3'h1;
    endcase
  endfunction

  logic req;
  logic ack_q;
  logic wr_go;
  logic rd_go;
  logic [31:0] dat_q;
  logic [31:0] ctl_q;
  logic [31:0] en_q;
  logic [31:0] trig_q;
  logic [31:0] tx_data_q;
  logic [2:0] tx_size_q;
  logic tx_wr_q;
  logic rx_rd_q;
  logic [15:0] units_q;
  spi_status_pkg::xfer_state_t state_q;
  spi_status_pkg::xfer_state_t state_d;
  logic manual;
  logic dma_mode;
  logic desc_mode;
  logic len_hit;
  logic stop_done;
  logic done_evt;
  logic [15:0] tx_cnt;
  logic [15:0] rx_cnt;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic tx_over;
  logic rx_under;
  logic tx_req;
  logic rx_req;
  logic [NS-1:0] sticky_set;
  logic [NS-1:0] sticky_clr;
  logic [NS-1:0] sticky;
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic tx_port_wr;
  logic rx_port_rd;

  // Classic Wishbone: ack one cycle after request, effects at ack edge
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_go = req && ack_q && wb_we_i;
  assign rd_go = req && ack_q && !wb_we_i;
  assign tx_port_wr = wr_go && hit(wb_adr_i, `OFF_TX_PORT);
  assign rx_port_rd = rd_go && hit(wb_adr_i, `OFF_RX_PORT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(wb_adr_i, `OFF_CONTROL)) begin
      rd_mux = ctl_q;
    end else if (hit(wb_adr_i, `OFF_STATUS)) begin
      rd_mux = status;
    end else if (hit(wb_adr_i, `OFF_COUNTS)) begin
      rd_mux = {rx_cnt, tx_cnt};
    end else if (hit(wb_adr_i, `OFF_ENABLES)) begin
      rd_mux = en_q;
    end else if (hit(wb_adr_i, `OFF_TRIGGERS)) begin
      rd_mux = trig_q;
    end else if (hit(wb_adr_i, `OFF_RX_PORT)) begin
      rd_mux = {24'h00_0000, rx_data_i};
    end
  end

  // Read data captured in the request cycle, held through ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !ack_q && !wb_we_i) begin
      dat_q <= rd_mux;
    end
  end

  // Control: stop self-clears once the stop has been honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= `CONTROL_RESET;
    end else if (wr_go && hit(wb_adr_i, `OFF_CONTROL)) begin
      ctl_q <= wb_dat_i;
    end else if (stop_done) begin
      ctl_q[`CTL_STOP] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= `ENABLES_RESET;
    end else if (wr_go && hit(wb_adr_i, `OFF_ENABLES)) begin
      en_q <= wb_dat_i & `ENABLES_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= `TRIGGERS_RESET;
    end else if (wr_go && hit(wb_adr_i, `OFF_TRIGGERS)) begin
      trig_q <= wb_dat_i;
    end
  end

  // Transmit port: data handed to the buffer with its access size
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_q <= 32'h0000_0000;
      tx_size_q <= 3'h0;
      tx_wr_q <= 1'b0;
      rx_rd_q <= 1'b0;
    end else begin
      tx_wr_q <= tx_port_wr && !tx_over;
      rx_rd_q <= rx_port_rd && !rx_under;
      if (tx_port_wr) begin
        tx_data_q <= wb_dat_i;
        tx_size_q <= size_of(wb_sel_i);
      end
    end
  end

  fill_counter #(
    .CW(16),
    .DEPTH(TX_DEPTH)
  ) u_tx_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .add_en_i(tx_port_wr),
    .add_amt_i(size_of(wb_sel_i)),
    .sub_en_i(tx_pop_i),
    .sub_amt_i(3'h1),
    .count_o(tx_cnt),
    .full_o(tx_full),
    .empty_o(tx_empty),
    .over_o(tx_over),
    .under_o()
  );

  fill_counter #(
    .CW(16),
    .DEPTH(RX_DEPTH)
  ) u_rx_count (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .add_en_i(rx_push_i),
    .add_amt_i(3'h1),
    .sub_en_i(rx_port_rd),
    .sub_amt_i(size_of(wb_sel_i)),
    .count_o(rx_cnt),
    .full_o(rx_full),
    .empty_o(rx_empty),
    .over_o(),
    .under_o(rx_under)
  );

  // Watermarks; a zero trigger keeps the request low
  assign rx_req = (trig_q[31:16] != 16'h0000) && (rx_cnt >= trig_q[31:16]);
  assign tx_req = (trig_q[15:0] != 16'h0000) && (tx_cnt <= trig_q[15:0]);

  // Mode decode
  assign dma_mode = ctl_q[`CTL_DMA_EN] && !ctl_q[`CTL_DESC_EN];
  assign desc_mode = ctl_q[`CTL_DESC_EN];
  assign manual = !ctl_q[`CTL_DMA_EN] && !ctl_q[`CTL_DESC_EN];
  // Length zero means endless, so it never completes on count
  assign len_hit = manual && (state_q == spi_status_pkg::ST_RUN) && unit_done_i
    && (ctl_q[31:16] != 16'h0000) && (units_q + 16'h0001 == ctl_q[31:16]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      units_q <= 16'h0000;
    end else if (start_i || state_q == spi_status_pkg::ST_IDLE) begin
      units_q <= 16'h0000;
    end else if (unit_done_i) begin
      units_q <= units_q + 16'h0001;
    end
  end

  // Stop waits for the byte in flight to finish
  always_comb begin
    state_d = state_q;
    stop_done = 1'b0;
    case (state_q)
      spi_status_pkg::ST_IDLE: begin
        if (ctl_q[`CTL_STOP]) begin
          stop_done = 1'b1;
        end else if (start_i) begin
          state_d = spi_status_pkg::ST_RUN;
        end
      end
      spi_status_pkg::ST_RUN: begin
        if (len_hit) begin
          state_d = spi_status_pkg::ST_IDLE;
        end else if (ctl_q[`CTL_STOP]) begin
          state_d = spi_status_pkg::ST_STOP;
        end
      end
      spi_status_pkg::ST_STOP: begin
        if (byte_end_i) begin
          stop_done = 1'b1;
          state_d = spi_status_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = spi_status_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= spi_status_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Intermediate descriptors raise DMA-done only, not transfer-done
  assign done_evt = len_hit || stop_done
    || (dma_mode && dma_done_i)
    || (desc_mode && desc_done_i && desc_last_i);

  assign sticky_set[`BIT_DONE] = done_evt;
  assign sticky_set[`BIT_DMA] = dma_done_i;
  assign sticky_set[`BIT_TX_ERR] = tx_over;
  assign sticky_set[`BIT_RX_ERR] = rx_under;
  assign sticky_set[`BIT_PROG_ERR] = prog_err_i;
  // Write one clears; reading leaves the flags alone
  assign sticky_clr = (wr_go && hit(wb_adr_i, `OFF_STATUS)) ? wb_dat_i[NS-1:0] : '0;

  sticky_flags #(
    .W(NS)
  ) u_sticky (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(sticky_set),
    .clr_i(sticky_clr),
    .flag_o(sticky)
  );

  always_comb begin
    status = 32'h0000_0000;
    status[NS-1:0] = sticky;
    status[`BIT_TX_FULL] = tx_full;
    status[`BIT_TX_EMPTY] = tx_empty;
    status[`BIT_TX_REQ] = tx_req;
    status[`BIT_RX_FULL] = rx_full;
    status[`BIT_RX_EMPTY] = rx_empty;
    status[`BIT_RX_REQ] = rx_req;
  end

  // Level interrupt; levels such as rx empty follow the buffer live
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & en_q);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign tx_data_o = tx_data_q;
  assign tx_size_o = tx_size_q;
  assign tx_wr_o = tx_wr_q;
  assign rx_rd_o = rx_rd_q;
  assign stop_req_o = ctl_q[`CTL_STOP];
  assign dma_en_o = ctl_q[`CTL_DMA_EN];
  assign desc_en_o = ctl_q[`CTL_DESC_EN];

  sequence s_stop_byte;
    state_q == spi_status_pkg::ST_STOP ##0 byte_end_i;
  endsequence

  sequence s_done_seen;
    sticky[`BIT_DONE] ##0 !ctl_q[`CTL_STOP];
  endsequence

  done_manual_a: assert property (@(posedge clk_i) disable iff (rst_i)
    len_hit |=> sticky[`BIT_DONE] && state_q == spi_status_pkg::ST_IDLE)
    else $error("manual transfer did not complete");

  dma_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_mode && dma_done_i |=> sticky[`BIT_DONE] && sticky[`BIT_DMA])
    else $error("dma done without transfer done");

  desc_last_a: assert property (@(posedge clk_i) disable iff (rst_i)
    desc_mode && !desc_last_i && !len_hit && !stop_done && !sticky[`BIT_DONE]
    |=> !sticky[`BIT_DONE])
    else $error("done set by non-last descriptor");

  stop_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stop_byte |=> s_done_seen)
    else $error("stop did not complete after byte");

  done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sticky_clr[`BIT_DONE] && !done_evt |=> !sticky[`BIT_DONE])
    else $error("done flag not cleared by write one");

  rx_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_push_i && !rx_port_rd && !rx_full |=> rx_cnt == $past(rx_cnt) + 16'h0001)
    else $error("receive count did not rise");

  tx_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_port_wr && wb_sel_i == 4'hF && !tx_over && !tx_pop_i
    |=> tx_cnt == $past(tx_cnt) + 16'h0004)
    else $error("transmit count did not rise by four");

  tx_over_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_port_wr && tx_full |=> sticky[`BIT_TX_ERR] && tx_cnt == $past(tx_cnt) - 16'(tx_pop_i))
    else $error("overflow not flagged");

  rx_under_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_port_rd && rx_empty |=> sticky[`BIT_RX_ERR] && !rx_rd_o)
    else $error("underflow not flagged");

  rx_mark_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_q[31:16] == 16'h0000 |-> !status[`BIT_RX_REQ])
    else $error("receive request with zero trigger");

  tx_mark_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_cnt > trig_q[15:0] |-> !status[`BIT_TX_REQ])
    else $error("transmit request above trigger");

  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(en_q) == 32'h0000_0000 && !$past(rst_i) |-> !irq_o)
    else $error("interrupt with all enables off");
endmodule // spi_status_irq

/* File: verif/spi_engine_model.sv */
// Behavioural shift engine that sits beside the status block.
// Assumes one bench process calls fire() at a time, on the block clock.
`timescale 1ns/1ps
module spi_engine_model (
  input wire logic clk_i,
  output logic [7:0] ev_o,
  output logic last_o,
  output logic [7:0] data_o
);
  initial begin
    ev_o = 8'h00;
    last_o = 1'b0;
    data_o = 8'hA5;
  end
  // Head byte moves every cycle, so a stale value is never taken for data
  always @(posedge clk_i) begin
    data_o <= data_o * 8'h05 + 8'h01;
  end
  // Pulse one event line; gap gives a slow engine some idle cycles first
  task automatic fire(input int b, input logic last, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    ev_o[b] <= 1'b1;
    last_o <= last;
    @(posedge clk_i);
    ev_o <= 8'h00;
    last_o <= ~last;
  endtask
endmodule // spi_engine_model

/* File: verif/test_spi_status_irq.sv */
// Self-checking bench of the status block over classic Wishbone.
// Assumes the engine model drives the event pulses and rx head byte.
`timescale 1ns/1ps
`include "spi_status_params.svh"
module test_spi_status_irq;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] ev;
  logic last;
  logic [7:0] rxd;
  logic irq;
  logic [31:0] txd;
  logic [2:0] txs;
  logic txw;
  logic rxr;
  logic stp;
  logic dmae;
  logic dsce;
  int rx_pops = 0;
  // Size and data of each tx port write that must reach the buffer
  logic [34:0] tx_q[$];
  int err_count = 0;
  int n_checks = 0;
  int seed = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  always #12.5 clk_i = ~clk_i;
  spi_status_irq i_spi_status_irq (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .start_i(ev[0]), .unit_done_i(ev[1]),
    .byte_end_i(ev[2]), .dma_done_i(ev[3]), .desc_done_i(ev[4]), .desc_last_i(last),
    .prog_err_i(ev[5]), .tx_pop_i(ev[6]), .rx_push_i(ev[7]), .rx_data_i(rxd),
    .tx_data_o(txd), .tx_size_o(txs), .tx_wr_o(txw), .rx_rd_o(rxr), .stop_req_o(stp),
    .dma_en_o(dmae), .desc_en_o(dsce), .irq_o(irq));
  spi_engine_model i_spi_engine_model (.clk_i(clk_i), .ev_o(ev), .last_o(last),
    .data_o(rxd));
  task automatic test_done();
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Request held until ack is sampled high; no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) begin
      err_count++;
      $display("Error ack expected 1 seen %b", ack);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    wb(1'b1, a, s, d);
  endtask
  // Size zero marks a write that must be refused and never handed on
  task automatic wr_tx(input logic [3:0] s, input logic [31:0] d, input logic [2:0] n);
    if (n != 3'h0) begin
      tx_q.push_back({n, d});
    end
    wr(`OFF_TX_PORT, s, d);
  endtask
  task automatic chk_tx(input logic [34:0] e);
    n_checks++;
    if ({txs, txd} !== e) begin
      err_count++;
      $display("Error tx handoff expected %h seen %h", e, {txs, txd});
    end
  endtask
  task automatic chk_lvl(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Control levels change at the ack edge, so look one edge later
  task automatic chk_ctl(input logic [31:0] e);
    @(posedge clk_i);
    chk_lvl("control outputs", e, {29'h0000_0000, dsce, dmae, stp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(1'b0, a, s, 32'h0000_0000);
  endtask
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] m);
    n_checks++;
    if ((rdat & m) !== (e & m)) begin
      err_count++;
      $display("Error read %h expected %h seen %h", adr, e & m, rdat & m);
    end
  endtask
  // Irq is a registered level, so let it settle before looking
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk_i);
    n_checks++;
    if (irq !== e) begin
      err_count++;
      $display("Error irq expected %b seen %b", e, irq);
    end
  endtask
  task automatic ev_n(input int b, input int n);
    repeat (n) i_spi_engine_model.fire(b, 1'b0, $urandom_range(2));
  endtask
  // Oldest noted read is compared when its ack shows up
  always @(posedge clk_i) begin
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk_rd(exp_q.pop_front(), msk_q.pop_front());
    end
  end
  // Tx handoff pulses are matched to the oldest accepted write
  always @(posedge clk_i) begin
    if (txw === 1'b1) begin
      if (tx_q.size() > 0) begin
        chk_tx(tx_q.pop_front());
      end else begin
        chk_tx(35'h0_0000_0000);
      end
    end
    if (rxr === 1'b1) begin
      rx_pops++;
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end
  initial begin
    seed = $urandom(31);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFF_COUNTS, 4'hF, 32'h0000_0000, ALL);
    rd(`OFF_ENABLES, 4'hF, `ENABLES_RESET, ALL);
    rd(`OFF_TRIGGERS, 4'hF, `TRIGGERS_RESET, ALL);
    rd(`OFF_STATUS, 4'hF, 32'h0000_2200, ALL);
    chk_irq(1'b1);
    wr(`OFF_ENABLES, 4'hF, 32'h0000_0000);
    chk_irq(1'b0);
    wr(`OFF_ENABLES, 4'hF, ALL);
    rd(`OFF_ENABLES, 4'hF, `ENABLES_MASK, ALL);
    wr(`OFF_ENABLES, 4'hF, 32'h0000_0000);
    wr_tx(4'hF, $urandom(), 3'h4);
    wr_tx(4'h3, {16'h0000, 16'($urandom())}, 3'h2);
    wr_tx(4'h1, {24'h00_0000, 8'($urandom())}, 3'h1);
    rd(`OFF_COUNTS, 4'hF, 32'h0000_0007, ALL);
    // Two bytes into one free slot must be refused whole
    wr_tx(4'h3, 32'h0000_1234, 3'h0);
    rd(`OFF_COUNTS, 4'hF, 32'h0000_0007, ALL);
    rd(`OFF_STATUS, 4'hF, 32'h0000_2004, ALL);
    wr_tx(4'h1, 32'h0000_0056, 3'h1);
    wr(`OFF_COUNTS, 4'hF, ALL);
    rd(`OFF_COUNTS, 4'hF, 32'h0000_0008, ALL);
    wr(`OFF_STATUS, 4'hF, 32'h0000_0004);
    rd(`OFF_STATUS, 4'hF, 32'h0000_2100, ALL);
    // A byte into a full buffer must be refused and flagged
    wr_tx(4'h1, 32'h0000_0078, 3'h0);
    rd(`OFF_COUNTS, 4'hF, 32'h0000_0008, ALL);
    rd(`OFF_STATUS, 4'hF, 32'h0000_2104, ALL);
    wr(`OFF_STATUS, 4'hF, 32'h0000_0004);
    ev_n(6, 8);
    ev_n(7, 3);
    rd(`OFF_COUNTS, 4'hF, 32'h0003_0000, ALL);
    wr(`OFF_TRIGGERS, 4'hF, 32'h0003_0002);
    rd(`OFF_STATUS, 4'hF, 32'h0000_4600, ALL);
    wr(`OFF_ENABLES, 4'hF, 32'h0000_0400);
    chk_irq(1'b1);
    wr(`OFF_ENABLES, 4'hF, 32'h0000_4000);
    chk_irq(1'b1);
    wr(`OFF_TRIGGERS, 4'hF, 32'h0004_0000);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0200, ALL);
    chk_irq(1'b0);
    rd(`OFF_RX_PORT, 4'h1, 32'h0000_0000, 32'hFFFF_FF00);
    rd(`OFF_COUNTS, 4'hF, 32'h0002_0000, ALL);
    rd(`OFF_RX_PORT, 4'h3, 32'h0000_0000, 32'hFFFF_0000);
    rd(`OFF_RX_PORT, 4'h1, 32'h0000_0000, 32'hFFFF_FF00);
    rd(`OFF_STATUS, 4'hF, 32'h0000_2208, ALL);
    wr(`OFF_STATUS, 4'hF, 32'h0000_0008);
    ev_n(7, 8);
    wr(`OFF_ENABLES, 4'hF, 32'h0000_1000);
    chk_irq(1'b1);
    rd(`OFF_RX_PORT, 4'hF, 32'h0000_0000, 32'h0000_0000);
    rd(`OFF_RX_PORT, 4'hF, 32'h0000_0000, 32'h0000_0000);
    rd(`OFF_COUNTS, 4'hF, 32'h0000_0000, ALL);
    wr(`OFF_ENABLES, 4'hF, 32'h0000_001F);
    ev_n(5, 1);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0010, 32'h0000_001F);
    chk_irq(1'b1);
    wr(`OFF_STATUS, 4'hF, 32'h0000_001F);
    chk_irq(1'b0);
    wr(`OFF_CONTROL, 4'hF, 32'h0002_0000);
    ev_n(0, 1);
    ev_n(1, 1);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0000, 32'h0000_0001);
    ev_n(1, 1);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0001, 32'h0000_0003);
    chk_irq(1'b1);
    wr(`OFF_STATUS, 4'hF, 32'h0000_0001);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0000, 32'h0000_0001);
    wr(`OFF_CONTROL, 4'hF, 32'h0000_0002);
    chk_ctl(32'h0000_0002);
    ev_n(3, 1);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0003, 32'h0000_0003);
    wr(`OFF_STATUS, 4'hF, 32'h0000_0003);
    wr(`OFF_CONTROL, 4'hF, 32'h0000_0004);
    chk_ctl(32'h0000_0004);
    ev_n(4, 1);
    ev_n(3, 1);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0002, 32'h0000_0003);
    i_spi_engine_model.fire(4, 1'b1, 3);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0003, 32'h0000_0003);
    wr(`OFF_STATUS, 4'hF, 32'h0000_0003);
    wr(`OFF_CONTROL, 4'hF, 32'h0005_0000);
    ev_n(0, 1);
    ev_n(1, 1);
    wr(`OFF_CONTROL, 4'hF, 32'h0005_0001);
    chk_ctl(32'h0000_0001);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0000, 32'h0000_0001);
    ev_n(2, 1);
    chk_ctl(32'h0000_0000);
    rd(`OFF_STATUS, 4'hF, 32'h0000_0001, 32'h0000_0001);
    rd(8'h40, 4'hF, 32'h0000_0000, ALL);
    repeat (5) @(posedge clk_i);
    chk_lvl("tx handoffs missing", 32'h0000_0000, tx_q.size());
    chk_lvl("rx read pulses", 32'h0000_0004, rx_pops);
    test_done();
  end
endmodule // test_spi_status_irq
